// ---- hw/ppp_pkg.sv ----
// Constants and types for the parallel PROM programmer controller.
// Assumes a 10 MHz system clock.
package ppp_pkg;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          PULSE_NS        = 100_000;
    localparam int          PULSE_CYC       = (PULSE_NS * (CLK_HZ / 1_000_000)
                                               + 999) / 1000;
    localparam int          SETUP_CYC       = 2;
    localparam int          MAX_TRIES       = 10;
    localparam int          PAGE_BYTES      = 4;
    localparam int          ADDR_W          = 17;
    localparam int          DATA_W          = 8;
    localparam logic [16:0] LAST_ADDR       = 17'h0efff;
    localparam logic [7:0]  ERASED_BYTE     = 8'hff;
    localparam logic [3:0]  TRY_RST         = 4'h0;

    typedef enum logic [1:0] {
        PPP_OP_READ,
        PPP_OP_BYTE,
        PPP_OP_PAGE
    } ppp_op_t;

    typedef enum logic [3:0] {
        PPP_IDLE,
        PPP_LATCH,
        PPP_LATCH_GAP,
        PPP_PULSE,
        PPP_RECOVER,
        PPP_VERIFY,
        PPP_SAMPLE,
        PPP_DONE
    } ppp_state_t;
endpackage : ppp_pkg

// ---- hw/ppp_page_buf.sv ----
// Four-byte page buffer with registered read data.
// Assumes the controller writes before reading back.
`timescale 1ns/1ps
`default_nettype none
module ppp_page_buf #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 8
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_we,
    input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input  wire logic [WIDTH-1:0]         i_wdata,
    input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic      [WIDTH-1:0]         o_rdata
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_q[i_raddr];
    end
endmodule : ppp_page_buf
`default_nettype wire

// ---- hw/ppp_ctrl.sv ----
// Host-side controller that drives a PROM through its parallel pins.
// Assumes supply levels are applied by the caller, pins synchronous.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Hold reset low, require supply level
// - Latch page: chip high, strobe high, oe low
// - One pulse, chip and oe high
// - Byte write: chip low, oe high, pulse
// - Retry write and verify at most ten
// - Refuse writes past last address
// - Read presents seventeen address bits
module ppp_ctrl
    import ppp_pkg::*;
#(
    parameter int PULSE_CYCLES = ppp_pkg::PULSE_CYC,
    parameter int TRIES        = ppp_pkg::MAX_TRIES
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_supply_ok,
    input  wire logic                  i_start,
    input  wire ppp_pkg::ppp_op_t      i_op,
    input  wire logic [16:0]           i_addr,
    input  wire logic [31:0]           i_wdata,
    output logic                       o_busy,
    output logic                       o_done,
    output logic                       o_ok,
    output logic                       o_refused,
    output logic                       o_erased,
    output logic [7:0]                 o_rdata,
    output logic                       o_reset_n,
    output logic                       o_chip_sel_n,
    output logic                       o_out_en_n,
    output logic                       program_strobe_n,
    output logic [16:0]                prom_address_bus,
    output logic [7:0]                 prom_data_bus_o,
    output logic                       prom_data_bus_oe,
    input  wire logic [7:0]            prom_data_bus_i
);
    import ppp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    ppp_state_t  st_q,    st_d;
    ppp_op_t     op_q,    op_d;
    logic [16:0] base_q,  base_d;
    logic [31:0] wd_q,    wd_d;
    logic [1:0]  idx_q,   idx_d;
    logic [3:0]  try_q,   try_d;
    logic [15:0] cnt_q,   cnt_d;
    logic        bad_q,   bad_d;
    logic        done_q,  done_d;
    logic        ok_q,    ok_d;
    logic        ref_q,   ref_d;
    logic [7:0]  rd_q,    rd_d;
    logic        cs_q,    cs_d;
    logic        oe_q,    oe_d;
    logic        pg_q,    pg_d;
    logic        drv_q,   drv_d;
    logic [16:0] ad_q,    ad_d;
    logic [7:0]  dq_q,    dq_d;
    logic [7:0]  buf_rd;

    function automatic logic [7:0] pick(input logic [31:0] w,
                                        input logic [1:0] i);
        pick = w[8*i +: 8];
    endfunction : pick

    ppp_page_buf #(.DEPTH(PAGE_BYTES), .WIDTH(DATA_W)) u_buf (
        .i_clk   (i_clk),
        .i_we    (st_q == PPP_SAMPLE),
        .i_waddr (idx_q),
        .i_wdata (prom_data_bus_i),
        .i_raddr (idx_q),
        .o_rdata (buf_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_d = st_q; op_d = op_q; base_d = base_q; wd_d = wd_q;
        idx_d = idx_q; try_d = try_q; cnt_d = cnt_q; bad_d = bad_q;
        done_d = 1'b0; ok_d = ok_q; ref_d = 1'b0; rd_d = rd_q;
        cs_d = 1'b1; oe_d = 1'b1; pg_d = 1'b1; drv_d = 1'b0;
        ad_d = ad_q; dq_d = dq_q;
        case (st_q)
            PPP_IDLE: begin
                if (i_start && i_supply_ok) begin
                    if (i_op != PPP_OP_READ && (i_addr > LAST_ADDR ||
                        (i_op == PPP_OP_PAGE &&
                         i_addr + 17'h3 > LAST_ADDR))) begin
                        ref_d = 1'b1;
                        done_d = 1'b1;
                    end else begin
                        op_d = i_op; base_d = i_addr; wd_d = i_wdata;
                        idx_d = 2'h0; try_d = TRY_RST; bad_d = 1'b0;
                        cnt_d = 16'(SETUP_CYC);
                        ad_d = i_addr;
                        st_d = (i_op == PPP_OP_PAGE) ? PPP_LATCH :
                               (i_op == PPP_OP_BYTE) ? PPP_PULSE
                                                     : PPP_VERIFY;
                        if (i_op == PPP_OP_BYTE) begin
                            cnt_d = 16'(PULSE_CYCLES);
                            dq_d = pick(i_wdata, 2'h0);
                        end
                    end
                end else if (i_start) begin
                    ref_d = 1'b1;
                    done_d = 1'b1;
                end
            end
            PPP_LATCH: begin
                cs_d = 1'b1; oe_d = 1'b0; pg_d = 1'b1; drv_d = 1'b1;
                ad_d = base_q + 17'(idx_q);
                dq_d = pick(wd_q, idx_q);
                cnt_d = cnt_q - 16'h1;
                if (cnt_q == 16'h0) begin
                    st_d = PPP_LATCH_GAP;
                end
            end
            PPP_LATCH_GAP: begin
                cnt_d = 16'(SETUP_CYC);
                if (idx_q == 2'(PAGE_BYTES - 1)) begin
                    idx_d = 2'h0;
                    cnt_d = 16'(PULSE_CYCLES);
                    st_d = PPP_PULSE;
                end else begin
                    idx_d = idx_q + 2'h1;
                    st_d = PPP_LATCH;
                end
            end
            PPP_PULSE: begin
                pg_d = 1'b0;
                cs_d = (op_q == PPP_OP_PAGE);
                oe_d = 1'b1;
                drv_d = (op_q == PPP_OP_BYTE);
                cnt_d = cnt_q - 16'h1;
                if (cnt_q == 16'h1) begin
                    try_d = try_q + 4'h1;
                    cnt_d = 16'(SETUP_CYC);
                    st_d = PPP_RECOVER;
                end
            end
            PPP_RECOVER: begin
                cnt_d = 16'(SETUP_CYC);
                idx_d = 2'h0;
                bad_d = 1'b0;
                st_d = PPP_VERIFY;
            end
            PPP_VERIFY: begin
                cs_d = 1'b0; oe_d = 1'b0; pg_d = 1'b1;
                ad_d = base_q + 17'(idx_q);
                cnt_d = cnt_q - 16'h1;
                if (cnt_q == 16'h0) begin
                    st_d = PPP_SAMPLE;
                end
            end
            PPP_SAMPLE: begin
                rd_d = prom_data_bus_i;
                if (op_q != PPP_OP_READ &&
                    prom_data_bus_i != pick(wd_q, idx_q)) begin
                    bad_d = 1'b1;
                end
                cnt_d = 16'(SETUP_CYC);
                if (op_q != PPP_OP_PAGE || idx_q == 2'(PAGE_BYTES - 1)) begin
                    st_d = PPP_DONE;
                end else begin
                    idx_d = idx_q + 2'h1;
                    st_d = PPP_VERIFY;
                end
            end
            PPP_DONE: begin
                if (bad_q && try_q < 4'(TRIES)) begin
                    idx_d = 2'h0;
                    cnt_d = 16'(SETUP_CYC);
                    st_d = (op_q == PPP_OP_PAGE) ? PPP_LATCH : PPP_PULSE;
                    if (op_q == PPP_OP_BYTE) begin
                        cnt_d = 16'(PULSE_CYCLES);
                    end
                end else begin
                    ok_d = !bad_q;
                    done_d = 1'b1;
                    st_d = PPP_IDLE;
                end
            end
            default: st_d = PPP_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= PPP_IDLE; op_q <= PPP_OP_READ; base_q <= '0;
            wd_q <= '0; idx_q <= '0; try_q <= TRY_RST; cnt_q <= '0;
            bad_q <= 1'b0; done_q <= 1'b0; ok_q <= 1'b0; ref_q <= 1'b0;
            rd_q <= '0; cs_q <= 1'b1; oe_q <= 1'b1; pg_q <= 1'b1;
            drv_q <= 1'b0; ad_q <= '0; dq_q <= '0;
        end else begin
            st_q <= st_d; op_q <= op_d; base_q <= base_d; wd_q <= wd_d;
            idx_q <= idx_d; try_q <= try_d; cnt_q <= cnt_d;
            bad_q <= bad_d; done_q <= done_d; ok_q <= ok_d;
            ref_q <= ref_d; rd_q <= rd_d; cs_q <= cs_d; oe_q <= oe_d;
            pg_q <= pg_d; drv_q <= drv_d; ad_q <= ad_d; dq_q <= dq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_busy           = (st_q != PPP_IDLE);
    assign o_done           = done_q;
    assign o_ok             = ok_q;
    assign o_refused        = ref_q;
    assign o_rdata          = rd_q;
    assign o_erased         = (rd_q == ERASED_BYTE);
    assign o_reset_n        = 1'b0;
    assign o_chip_sel_n     = cs_q;
    assign o_out_en_n       = oe_q;
    assign program_strobe_n = pg_q;
    assign prom_address_bus = ad_q;
    assign prom_data_bus_o  = dq_q;
    assign prom_data_bus_oe = drv_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence pulse_start_s;
        $fell(program_strobe_n);
    endsequence

    no_drive_oe_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !o_out_en_n |-> !(prom_data_bus_oe && !o_chip_sel_n))
        else $error("host drives bus while device reads");
    page_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (pulse_start_s and o_chip_sel_n) |-> o_out_en_n && !prom_data_bus_oe)
        else $error("page pulse pin levels wrong");
    byte_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (pulse_start_s and !o_chip_sel_n) |-> o_out_en_n && prom_data_bus_oe)
        else $error("byte pulse pin levels wrong");
    pulse_width_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        pulse_start_s |-> !program_strobe_n [*8])
        else $error("program pulse too short");
    latch_level_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == PPP_LATCH) |=> o_chip_sel_n && !o_out_en_n &&
                                program_strobe_n)
        else $error("latch pin levels wrong");
    verify_level_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == PPP_SAMPLE) |-> !o_chip_sel_n && !o_out_en_n &&
                                 program_strobe_n)
        else $error("verify pin levels wrong");
    try_limit_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        try_q <= 4'(TRIES))
        else $error("too many write attempts");
    addr_range_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !program_strobe_n |-> prom_address_bus <= LAST_ADDR)
        else $error("write outside address range");
    reset_low_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !o_reset_n)
        else $error("device reset released");
    buf_echo_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        done_q && !ref_q |-> buf_rd == rd_q)
        else $error("page buffer lost a sampled byte");
endmodule : ppp_ctrl
`default_nettype wire

// ---- tb/ppp_prom_model.sv ----
// Behavioural PROM on the far side of the programming pins.
// Assumes the bench resolves the shared data bus from the host enable alone.
`timescale 1ns/1ps
`default_nettype none
module ppp_prom_model (
    input  wire logic        i_reset_n,
    input  wire logic        i_chip_sel_n,
    input  wire logic        i_out_en_n,
    input  wire logic        i_strobe_n,
    input  wire logic [16:0] i_addr,
    input  wire logic [7:0]  i_data,
    output logic      [7:0]  o_data,
    output logic             o_data_oe
);
    logic [7:0]  mem [logic [16:0]];
    logic [16:0] lat_a [4];
    logic [7:0]  lat_d [4];
    logic [3:0]  lat_v = 4'h0;
    int          fails_left = 0;
    int          wr_cnt = 0;
    function automatic logic [7:0] rd(input logic [16:0] a);
        if (mem.exists(a)) return mem[a];
        return 8'hff;
    endfunction : rd
    ////////////////////////////////////////////////////////////////////
    // Drive only in verify or read; otherwise show a changing float
    always @(i_addr, i_chip_sel_n, i_out_en_n, i_strobe_n, i_reset_n,
             wr_cnt) begin
        o_data_oe = !i_reset_n && !i_chip_sel_n && !i_out_en_n
                    && i_strobe_n;
        o_data = o_data_oe ? rd(i_addr) : ~o_data;
    end
    ////////////////////////////////////////////////////////////////////
    // Page latch while chip high, strobe high, output enable low
    // Pins change together at a clock edge; judge them once settled
    always @(i_data, i_addr, i_chip_sel_n, i_out_en_n, i_strobe_n) begin
        #10;
        if (!i_reset_n && i_chip_sel_n && !i_out_en_n && i_strobe_n) begin
            lat_a[i_addr[1:0]] = i_addr;
            lat_d[i_addr[1:0]] = i_data;
            lat_v[i_addr[1:0]] = 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Program pulse: pins judged mid-cycle; cells only clear bits
    always @(negedge i_strobe_n) begin
        #50;
        if (!i_reset_n && i_out_en_n) begin
            if (fails_left > 0) begin
                fails_left--;
            end else if (i_chip_sel_n) begin
                for (int i = 0; i < 4; i++) begin
                    if (lat_v[i]) mem[lat_a[i]] = rd(lat_a[i]) & lat_d[i];
                end
            end else begin
                mem[i_addr] = rd(i_addr) & i_data;
            end
            lat_v = 4'h0;
            wr_cnt++;
        end
    end
endmodule : ppp_prom_model
`default_nettype wire

// ---- tb/test_ppp_ctrl.sv ----
// Self-checking bench for the PROM programmer controller.
// Assumes the PROM model in ppp_prom_model.sv.
`timescale 1ns/1ps
`default_nettype none
module test_ppp_ctrl;
    import ppp_pkg::*;
    logic i_clk, i_rstn, i_supply_ok, i_start;
    ppp_op_t i_op;
    logic [16:0] i_addr, addr_bus;
    logic [31:0] i_wdata;
    logic o_busy, o_done, o_ok, o_refused, o_erased, reset_n, cs_n, oe_n;
    logic strobe_n, host_oe, dev_oe;
    logic [7:0] o_rdata, host_d, dev_d, bus;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    assign bus = host_oe ? host_d : dev_d;
    ppp_ctrl #(.PULSE_CYCLES(8), .TRIES(10)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_supply_ok(i_supply_ok),
        .i_start(i_start), .i_op(i_op), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_ok(o_ok),
        .o_refused(o_refused), .o_erased(o_erased), .o_rdata(o_rdata),
        .o_reset_n(reset_n), .o_chip_sel_n(cs_n), .o_out_en_n(oe_n),
        .program_strobe_n(strobe_n), .prom_address_bus(addr_bus),
        .prom_data_bus_o(host_d), .prom_data_bus_oe(host_oe),
        .prom_data_bus_i(bus));
    ppp_prom_model dev (
        .i_reset_n(reset_n), .i_chip_sel_n(cs_n), .i_out_en_n(oe_n),
        .i_strobe_n(strobe_n), .i_addr(addr_bus), .i_data(bus),
        .o_data(dev_d), .o_data_oe(dev_oe));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic stop_test;
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    always @(posedge i_clk) begin
        cyc++;
        if (host_oe && dev_oe) begin
            fail_count++;
            $display("Error at %0t: both sides drive the data bus", $time);
        end
        if (cyc == 40000) begin
            fail_count++;
            $display("Error at %0t: timeout", $time);
            stop_test();
        end
    end
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    ////////////////////////////////////////////////////////////////////
    // One operation: start pulse, bounded wait, outcome flags
    task automatic run(input ppp_op_t op, input logic [16:0] a,
                       input logic [31:0] d, input logic ok, input logic rf);
        int n;
        i_op = op;
        i_addr = a;
        i_wdata = d;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        chk_bit(o_busy, !rf);
        n = 0;
        while (o_done !== 1'b1 && n < 5000) begin
            @(negedge i_clk);
            n++;
        end
        chk_bit(o_done, 1'b1);
        chk_bit(o_ok, ok);
        chk_bit(o_refused, rf);
        chk_bit(o_busy, 1'b0);
        @(negedge i_clk);
    endtask : run
    task automatic rd(input logic [16:0] a, input logic [7:0] e);
        run(PPP_OP_READ, a, 32'h0, 1'b1, 1'b0);
        chk_byte(o_rdata, e);
    endtask : rd
    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_erased;
        rd(17'h00123, 8'hff);
        chk_bit(o_erased, 1'b1);
        rd(17'h1fffe, 8'hff);
    endtask : t_erased
    task automatic t_byte;
        run(PPP_OP_BYTE, 17'h00010, 32'h3c, 1'b1, 1'b0);
        rd(17'h00010, 8'h3c);
        chk_bit(o_erased, 1'b0);
        run(PPP_OP_BYTE, 17'h0efff, 32'ha5, 1'b1, 1'b0);
        rd(17'h0efff, 8'ha5);
    endtask : t_byte
    task automatic t_page;
        run(PPP_OP_PAGE, 17'h00101, 32'h44332211, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rd(17'h00101 + 17'(i), 8'h11 * 8'(i + 1));
        end
        rd(17'h00100, 8'hff);
    endtask : t_page
    task automatic t_retry;
        dev.fails_left = 3;
        run(PPP_OP_BYTE, 17'h00020, 32'h5a, 1'b1, 1'b0);
        rd(17'h00020, 8'h5a);
        dev.fails_left = 12;
        run(PPP_OP_BYTE, 17'h00030, 32'h00, 1'b0, 1'b0);
        chk_bit(dev.fails_left == 2, 1'b1);
        dev.fails_left = 0;
        rd(17'h00030, 8'hff);
    endtask : t_retry
    task automatic t_refuse;
        // A refusal leaves the outcome flag of the last operation alone
        run(PPP_OP_BYTE, 17'h0f000, 32'h00, 1'b1, 1'b1);
        run(PPP_OP_PAGE, 17'h0effd, 32'h0, 1'b1, 1'b1);
        rd(17'h0f000, 8'hff);
        rd(17'h0effd, 8'hff);
        run(PPP_OP_PAGE, 17'h0effc, 32'h01030507, 1'b1, 1'b0);
        rd(17'h0effc, 8'h07);
        i_supply_ok = 1'b0;
        run(PPP_OP_READ, 17'h0, 32'h0, 1'b1, 1'b1);
        i_supply_ok = 1'b1;
    endtask : t_refuse
    initial begin
        i_rstn = 1'b0;
        i_supply_ok = 1'b1;
        i_start = 1'b0;
        i_op = PPP_OP_READ;
        i_addr = 17'h0;
        i_wdata = 32'h0;
        repeat (2) @(negedge i_clk);
        i_rstn = 1'b1;
        @(negedge i_clk);
        chk_bit(reset_n, 1'b0);
        t_erased();
        t_byte();
        t_page();
        t_retry();
        t_refuse();
        stop_test();
    end
endmodule : test_ppp_ctrl
`default_nettype wire
